// ===== design/rss_pkg.sv
// rss_pkg: constants, types and carriers for the reset start-up sequencer.
// assumes a single 250 MHz system clock; no module or process lives here.
package rss_pkg;

  // clock rate and start-up times in their own units
  localparam int unsigned CLK_MHZ       = 250;
  localparam int unsigned POWER_UP_TIMER_MS       = 96;
  localparam int unsigned POWER_UP_TIMER_CYCLES   = POWER_UP_TIMER_MS * CLK_MHZ * 1000;
  localparam int unsigned OST_PERIODS   = 1024;

  // counter widths sized to hold the loads above
  localparam int          POWER_UP_TIMER_W        = 25;
  localparam int          OST_W         = 11;

  // register bus geometry and map
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 8;
  localparam logic [7:0]  ADDR_IRQ_STAT = 8'h00;
  localparam logic [7:0]  ADDR_IRQ_MASK = 8'h01;
  localparam logic [7:0]  ADDR_SEQ_STAT = 8'h02;

  // interrupt status bit positions and reset values
  localparam int          IRQ_W         = 4;
  localparam int          IRQ_RELEASE   = 0;
  localparam int          IRQ_WDT       = 1;
  localparam int          IRQ_MASTER_CLEAR_N      = 2;
  localparam int          IRQ_WAKE      = 3;
  localparam logic [3:0]  IRQ_MASK_RST  = 4'h0;
  localparam logic [3:0]  CSTAT_RST     = 4'hf;

  // oscillator configuration
  typedef enum logic [1:0] {
    MODE_LF = 2'b00,
    MODE_XT = 2'b01,
    MODE_EC = 2'b10,
    MODE_RC = 2'b11
  } rss_osc_mode_t;

  // sequencer states, gray along hold -> timing -> run
  typedef enum logic [1:0] {
    ST_HOLD   = 2'b00,
    ST_TIMING = 2'b01,
    ST_RUN    = 2'b11
  } rss_state_t;

  // what the pending reset or wake asks of the sequence
  typedef struct packed {
    logic to;      // timeout cause flag value
    logic pd;      // power-down flag value
    logic power_up_timer;    // power-up timer needed
    logic oscillator_startup_counter;     // start-up counter allowed (crystal modes only)
    logic resume;  // continue at next instruction instead of vector
  } rss_plan_t;

  localparam rss_plan_t PLAN_POR = '{to: 1'b1, pd: 1'b1, power_up_timer: 1'b1,
                                     oscillator_startup_counter: 1'b1, resume: 1'b0};

endpackage

// ===== design/rss_tmr.sv
// rss_tmr: loadable down-counter that runs while busy, one step per tick.
// assumes start is only raised while idle; load value is at least one.
`timescale 1ns/1ps
module rss_tmr #(
  parameter int W = 11
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // control
  input  wire logic         start,
  input  wire logic         abort,
  input  wire logic         tick,
  input  wire logic [W-1:0] load_val,
  // state
  output logic              busy,
  output logic [W-1:0]      count
);

  wire last_step = busy && tick && (count == W'(1));

  // abort wins, so a held-off sequence never leaves a stale count running
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busy  <= 1'b0;
      count <= '0;
    end else if (abort) begin
      busy  <= 1'b0;
      count <= '0;
    end else if (start) begin
      busy  <= 1'b1;
      count <= load_val;
    end else if (busy && tick) begin
      busy  <= !last_step;
      count <= count - W'(1);
    end
  end

endmodule

// ===== design/rss_seq.sv
// rss_seq: reset and start-up sequencer for an 8-bit core.
// assumes all inputs are synchronous to sys_clk; osc_pulse is a one-cycle
// pulse per oscillator period seen on the clock input pin.
//
// What this block does
// - start-up counter waits 1024 oscillator periods after clear high or wake.
// - start-up delay only in crystal modes, only on power-on, wake, or clear or watchdog reset in sleep.
// - counter counts clock-pin pulses only once amplitude crosses thresholds.
// - on power-up with clear high in crystal modes, both timers start together.
// - power-up time-out is the longer of 96 ms and 1024 periods in crystal modes, 96 ms otherwise.
// - wake gets 1024 periods in crystal modes only; clear reset in run gets none.
// - time-out is measured from the rising edge of master clear.
// - power-on, clear reset in run, or clear-watchdog set both flags.
// - clear reset in sleep or interrupt wake: timeout 1, power-down 0.
// - watchdog reset in run: timeout 0, power-down 1.
// - watchdog reset in sleep clears both flags.
// - power-on, clear and watchdog resets restart at the reset vector.
// - interrupt wake resumes at next instruction, then vectors if enabled.
// - wake status reads 1110 with interrupts disabled, else 1010.
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module rss_seq #(
  parameter int unsigned POWER_UP_TIMER_CYCLES = rss_pkg::POWER_UP_TIMER_CYCLES
) (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // register port
  input  wire logic [7:0]            addr,
  input  wire logic [7:0]            wdata,
  input  wire logic                  wr,
  input  wire logic                  rd,
  output logic [7:0]                 rdata,
  // reset sources and core status
  input  wire logic                  por_ok,
  input  wire logic                  master_clear_n,
  input  wire logic                  wdt_timeout,
  input  wire logic                  wake_int,
  input  wire logic                  clear_watchdog_instr,
  input  wire logic                  sleeping,
  input  wire logic                  global_interrupt_disable,
  // oscillator
  input  wire rss_pkg::rss_osc_mode_t osc_mode,
  input  wire logic                  osc_pulse,
  input  wire logic                  osc_amp_ok,
  // to the core
  output logic                       core_hold,
  output logic                       pc_load,
  output logic                       pc_sel,
  output logic                       vector_after,
  output logic                       timeout_cause_flag,
  output logic                       power_down_flag,
  output logic [3:0]                 core_status_reg,
  output logic                       irq
);

  localparam logic [rss_pkg::POWER_UP_TIMER_W-1:0] POWER_UP_TIMER_LOAD =
    rss_pkg::POWER_UP_TIMER_W'(POWER_UP_TIMER_CYCLES);
  localparam logic [rss_pkg::OST_W-1:0] OST_LOAD =
    rss_pkg::OST_W'(rss_pkg::OST_PERIODS);

  rss_pkg::rss_state_t st;
  rss_pkg::rss_state_t next_st;
  rss_pkg::rss_plan_t  plan;
  rss_pkg::rss_plan_t  next_plan;
  logic [3:0]          irq_stat;
  logic [3:0]          irq_mask;
  logic [3:0]          next_irq_stat;
  logic                power_up_timer_busy;
  logic                ost_busy;
  logic [rss_pkg::POWER_UP_TIMER_W-1:0] power_up_timer_count;
  logic [rss_pkg::OST_W-1:0]  ost_count;

  // oscillator mode and run-time events, one at a time by priority
  wire mode_xtal  = (osc_mode == rss_pkg::MODE_XT) ||
                    (osc_mode == rss_pkg::MODE_LF);
  wire in_run     = (st == rss_pkg::ST_RUN);
  wire in_hold    = (st == rss_pkg::ST_HOLD);
  wire in_timing  = (st == rss_pkg::ST_TIMING);
  wire ev_por     = !por_ok;
  wire ev_master_clear_n    = in_run && por_ok && !master_clear_n;
  wire ev_wdt     = in_run && por_ok && master_clear_n && wdt_timeout;
  wire ev_wake    = in_run && por_ok && master_clear_n && !wdt_timeout &&
                    sleeping && wake_int;
  wire ev_clear_watchdog_instr  = in_run && por_ok && master_clear_n && !wdt_timeout &&
                    !sleeping && clear_watchdog_instr;

  // hold ends on the rising edge of clear with power good
  wire go         = in_hold && por_ok && master_clear_n;
  wire need_ost   = plan.oscillator_startup_counter && mode_xtal;
  wire power_up_timer_start = go && plan.power_up_timer;
  wire ost_start  = go && need_ost;
  wire direct_run = go && !plan.power_up_timer && !need_ost;
  // clear low or power loss stops any running sequence
  wire abort_seq  = !master_clear_n || !por_ok;
  wire ost_tick   = osc_pulse && osc_amp_ok;
  wire timers_idle = !power_up_timer_busy && !ost_busy;
  wire release_ok = (in_timing && timers_idle && !abort_seq) ||
                    direct_run;

  // flag and restart point chosen for each event
  wire rss_pkg::rss_plan_t plan_master_clear_n = '{to: 1'b1, pd: !sleeping,
                                         power_up_timer: 1'b0,
                                         oscillator_startup_counter: sleeping,
                                         resume: 1'b0};
  wire rss_pkg::rss_plan_t plan_wdt  = '{to: 1'b0, pd: !sleeping,
                                         power_up_timer: 1'b0, oscillator_startup_counter: sleeping,
                                         resume: 1'b0};
  wire rss_pkg::rss_plan_t plan_wake = '{to: 1'b1, pd: 1'b0,
                                         power_up_timer: 1'b0, oscillator_startup_counter: 1'b1,
                                         resume: 1'b1};

  // next plan: power loss first, then clear, watchdog, wake
  assign next_plan = ev_por  ? rss_pkg::PLAN_POR :
                     ev_master_clear_n ? plan_master_clear_n :
                     ev_wdt  ? plan_wdt  :
                     ev_wake ? plan_wake : plan;
  wire new_event   = ev_por || ev_master_clear_n || ev_wdt || ev_wake;

  // state decode
  always_comb begin
    next_st = st;
    case (st)
      rss_pkg::ST_HOLD: begin
        if (direct_run) begin
          next_st = rss_pkg::ST_RUN;
        end else if (go) begin
          next_st = rss_pkg::ST_TIMING;
        end
      end
      rss_pkg::ST_TIMING: begin
        if (abort_seq) begin
          next_st = rss_pkg::ST_HOLD;
        end else if (release_ok) begin
          next_st = rss_pkg::ST_RUN;
        end
      end
      rss_pkg::ST_RUN: begin
        if (new_event) begin
          next_st = rss_pkg::ST_HOLD;
        end
      end
      default: next_st = rss_pkg::ST_HOLD;
    endcase
  end

  // power-up timer and oscillator start-up counter
  rss_tmr #(.W(rss_pkg::POWER_UP_TIMER_W)) u_power_up_timer (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .start    (power_up_timer_start),
    .abort    (abort_seq),
    .tick     (1'b1),
    .load_val (POWER_UP_TIMER_LOAD),
    .busy     (power_up_timer_busy),
    .count    (power_up_timer_count)
  );

  rss_tmr #(.W(rss_pkg::OST_W)) u_oscillator_startup_counter (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .start    (ost_start),
    .abort    (abort_seq),
    .tick     (ost_tick),
    .load_val (OST_LOAD),
    .busy     (ost_busy),
    .count    (ost_count)
  );

  // sequencer state and pending plan
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st   <= rss_pkg::ST_HOLD;
      plan <= rss_pkg::PLAN_POR;
    end else begin
      st   <= next_st;
      plan <= next_plan;
    end
  end

  // core controls; hold drops only in the cycle the state reaches run
  wire release_now = (next_st == rss_pkg::ST_RUN) && !in_run;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      core_hold    <= 1'b1;
      pc_load      <= 1'b0;
      pc_sel       <= 1'b0;
      vector_after <= 1'b0;
    end else begin
      core_hold    <= (next_st != rss_pkg::ST_RUN);
      pc_load      <= release_now;
      pc_sel       <= release_now && plan.resume;
      vector_after <= release_now && plan.resume &&
                      !core_status_reg[2];
    end
  end

  // status flags, set when the event is taken so software sees the cause
  wire glint_bit = ev_wake ? global_interrupt_disable : 1'b1;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      timeout_cause_flag <= 1'b1;
      power_down_flag    <= 1'b1;
      core_status_reg    <= rss_pkg::CSTAT_RST;
    end else if (new_event) begin
      timeout_cause_flag <= next_plan.to;
      power_down_flag    <= next_plan.pd;
      core_status_reg    <= {1'b1, glint_bit, next_plan.to, next_plan.pd};
    end else if (ev_clear_watchdog_instr) begin
      timeout_cause_flag <= 1'b1;
      power_down_flag    <= 1'b1;
      core_status_reg    <= {core_status_reg[3:2], 2'b11};
    end
  end

  // register decode
  wire wr_stat  = wr && (addr == rss_pkg::ADDR_IRQ_STAT);
  wire wr_mask  = wr && (addr == rss_pkg::ADDR_IRQ_MASK);
  wire [3:0] ev_bits;
  assign ev_bits[rss_pkg::IRQ_RELEASE] = release_now;
  assign ev_bits[rss_pkg::IRQ_WDT]     = ev_wdt;
  assign ev_bits[rss_pkg::IRQ_MASTER_CLEAR_N]    = ev_master_clear_n;
  assign ev_bits[rss_pkg::IRQ_WAKE]    = ev_wake;
  // a new event in the clearing cycle survives the write of one
  assign next_irq_stat = (irq_stat & ~(wr_stat ? wdata[3:0] : 4'h0)) |
                         ev_bits;
  wire [7:0] rd_mux =
    (addr == rss_pkg::ADDR_IRQ_STAT) ? {4'h0, irq_stat} :
    (addr == rss_pkg::ADDR_IRQ_MASK) ? {4'h0, irq_mask} :
    (addr == rss_pkg::ADDR_SEQ_STAT) ? {st, power_up_timer_busy, ost_busy,
                                        core_status_reg} : 8'h00;

  // interrupt status, mask and level output
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_stat <= 4'h0;
      irq_mask <= rss_pkg::IRQ_MASK_RST;
      irq      <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq_mask <= wr_mask ? wdata[3:0] : irq_mask;
      irq      <= |(next_irq_stat & (wr_mask ? wdata[3:0] : irq_mask));
    end
  end

  // read data stands for the one cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rd ? rd_mux : 8'h00;
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  held_until_run_a: assert property (
    !in_run |-> core_hold)
    else $error("core released outside run state");

  release_timers_a: assert property (
    $fell(core_hold) |-> $past(timers_idle))
    else $error("core released with a timer still busy");

  ost_xtal_only_a: assert property (
    $rose(ost_busy) |-> $past(mode_xtal) && $past(plan.oscillator_startup_counter))
    else $error("start-up counter ran outside crystal modes");

  ost_amp_gate_a: assert property (
    ost_busy && !ost_tick && !abort_seq |=> $stable(ost_count))
    else $error("start-up counter moved without a valid pulse");

  ost_length_a: assert property (
    $rose(ost_busy) |-> ost_count == OST_LOAD)
    else $error("start-up counter not loaded with 1024");

  por_both_a: assert property (
    go && plan.power_up_timer && mode_xtal |=> power_up_timer_busy && ost_busy)
    else $error("power-up timers did not start together");

  power_up_timer_load_a: assert property (
    $rose(power_up_timer_busy) |-> power_up_timer_count == POWER_UP_TIMER_LOAD)
    else $error("power-up timer loaded with wrong count");

  start_on_edge_a: assert property (
    $rose(power_up_timer_busy) |-> $past(master_clear_n) && $past(in_hold))
    else $error("time-out began without a clear rising edge");

  master_clear_n_no_wait_a: assert property (
    ev_master_clear_n && !sleeping ##1 (master_clear_n && por_ok) |=> !core_hold)
    else $error("clear reset in run got a time-out");

  clear_watchdog_instr_flags_a: assert property (
    ev_clear_watchdog_instr |=> timeout_cause_flag && power_down_flag)
    else $error("clear-watchdog did not set both flags");

  sleep_clear_a: assert property (
    ev_master_clear_n && sleeping |=> timeout_cause_flag && !power_down_flag)
    else $error("clear in sleep flags wrong");

  wdt_run_flags_a: assert property (
    ev_wdt && !sleeping |=> !timeout_cause_flag && power_down_flag)
    else $error("watchdog in run flags wrong");

  wdt_sleep_flags_a: assert property (
    ev_wdt && sleeping |=> !timeout_cause_flag && !power_down_flag)
    else $error("watchdog in sleep flags wrong");

  vector_restart_a: assert property (
    ev_wdt ##1 (master_clear_n && por_ok && !mode_xtal)
      |=> pc_load && !pc_sel)
    else $error("watchdog reset did not restart at vector");

  wake_status_a: assert property (
    ev_wake |=> core_status_reg ==
      {1'b1, $past(global_interrupt_disable), 2'b10})
    else $error("wake core status wrong");

  abort_hold_a: assert property (
    in_timing && !master_clear_n |=> in_hold && timers_idle && core_hold)
    else $error("clear low did not abort the sequence");

  // restart point follows the plan that was pending at release
  restart_point_a: assert property (
    pc_load |-> pc_sel == $past(plan.resume))
    else $error("restart point does not match the pending plan");

  // vector request only when interrupts were enabled at the wake
  wake_vector_a: assert property (
    pc_load && pc_sel |-> vector_after == !core_status_reg[2])
    else $error("vector request does not follow interrupt disable");

  // clear-watchdog touches only the two cause bits
  clear_watchdog_instr_keep_a: assert property (
    ev_clear_watchdog_instr |=> $stable(core_status_reg[3:2]))
    else $error("clear-watchdog changed upper status bits");

  por_release_c: cover property (power_up_timer_busy && ost_busy ##[1:1000] pc_load);
  wake_resume_c: cover property (ev_wake ##[1:1000] pc_sel);
  wdt_sleep_c:   cover property (ev_wdt && sleeping);
  abort_c:       cover property (in_timing && !master_clear_n);
  master_clear_n_quick_c:  cover property (ev_master_clear_n ##1 master_clear_n ##1 pc_load);

endmodule

// ===== dv/rss_seq_test.sv
// rss_seq_test: self-checking bench for the reset start-up sequencer.
// assumes rss_pkg and rss_seq are compiled first; power-up timer shortened.
`timescale 1ns/1ps
module rss_seq_test;

  // power-up timer shortened so the run stays short
  localparam int unsigned POWER_UP_TIMER_SIM = 50;

  logic                   sys_clk = 1'b0;
  logic                   rst = 1'b1;
  logic [7:0]             addr = 8'h00;
  logic [7:0]             wdata = 8'h00;
  logic                   wr = 1'b0;
  logic                   rd = 1'b0;
  logic [7:0]             rdata;
  logic                   por_ok = 1'b1;
  logic                   master_clear_n = 1'b1;
  logic                   wdt_timeout = 1'b0;
  logic                   wake_int = 1'b0;
  logic                   clear_watchdog_instr = 1'b0;
  logic                   sleeping = 1'b0;
  logic                   global_interrupt_disable = 1'b1;
  rss_pkg::rss_osc_mode_t osc_mode = rss_pkg::MODE_XT;
  logic                   osc_pulse = 1'b0;
  logic                   osc_amp_ok = 1'b0;
  logic                   core_hold;
  logic                   pc_load;
  logic                   pc_sel;
  logic                   vector_after;
  logic                   timeout_cause_flag;
  logic                   power_down_flag;
  logic [3:0]             core_status_reg;
  logic                   irq;
  int                     err_count = 0;
  int                     compares = 0;

  // 250 MHz clock; oscillator pulse every other cycle
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) osc_pulse <= ~osc_pulse;

  rss_seq #(.POWER_UP_TIMER_CYCLES(POWER_UP_TIMER_SIM)) rss_seq_inst (
    .sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .por_ok(por_ok),
    .master_clear_n(master_clear_n), .wdt_timeout(wdt_timeout),
    .wake_int(wake_int), .clear_watchdog_instr(clear_watchdog_instr),
    .sleeping(sleeping),
    .global_interrupt_disable(global_interrupt_disable),
    .osc_mode(osc_mode), .osc_pulse(osc_pulse), .osc_amp_ok(osc_amp_ok),
    .core_hold(core_hold), .pc_load(pc_load), .pc_sel(pc_sel),
    .vector_after(vector_after), .timeout_cause_flag(timeout_cause_flag),
    .power_down_flag(power_down_flag), .core_status_reg(core_status_reg),
    .irq(irq)
  );

  // compare and count
  task check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // register port: one-cycle strobes, read data the cycle after
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask

  // waits for the release pulse and judges its timing and status
  task finish_seq(input int lo, input int hi, input logic sel,
                  input logic vec, input logic [3:0] cs);
    int n;
    n = 0;
    while (pc_load !== 1'b1 && n < 3000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check({7'h00, n >= lo && n <= hi}, 8'h01);
    check({3'h0, core_hold, pc_sel, vector_after, timeout_cause_flag,
           power_down_flag}, {4'h0, sel, vec, cs[1:0]});
    check({4'h0, core_status_reg}, {4'h0, cs});
    @(posedge sys_clk);
    sleeping <= 1'b0;
  endtask

  // power-on in crystal mode; amplitude low so the counter must not move
  task t_por();
    repeat (3) @(posedge sys_clk);
    rd_chk(rss_pkg::ADDR_SEQ_STAT, 8'h7f);
    repeat (60) @(posedge sys_clk);
    rd_chk(rss_pkg::ADDR_SEQ_STAT, 8'h5f);
    check({7'h00, core_hold}, 8'h01);
    @(posedge sys_clk);
    osc_amp_ok <= 1'b1;
    finish_seq(2040, 2064, 1'b0, 1'b0, 4'hf);
  endtask

  // clear reset while running in crystal mode: no delay at all
  task t_master_clear_n_run();
    @(posedge sys_clk);
    osc_mode <= rss_pkg::MODE_XT;
    master_clear_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    check({7'h00, core_hold}, 8'h01);
    @(posedge sys_clk);
    master_clear_n <= 1'b1;
    finish_seq(1, 6, 1'b0, 1'b0, 4'hf);
    // short clear pulse: release must follow at once, no time-out
    master_clear_n <= 1'b0;
    @(posedge sys_clk);
    master_clear_n <= 1'b1;
    finish_seq(1, 3, 1'b0, 1'b0, 4'hf);
  endtask

  // watchdog in run, then clear-watchdog restores both flags
  task t_wdt_run();
    @(posedge sys_clk);
    osc_mode <= rss_pkg::MODE_RC;
    wdt_timeout <= 1'b1;
    @(posedge sys_clk);
    wdt_timeout <= 1'b0;
    finish_seq(1, 6, 1'b0, 1'b0, 4'hd);
    @(posedge sys_clk);
    clear_watchdog_instr <= 1'b1;
    @(posedge sys_clk);
    clear_watchdog_instr <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    check({3'h0, core_hold, core_status_reg}, 8'h0f);
  endtask

  // watchdog while asleep in low-frequency crystal mode
  task t_wdt_sleep();
    @(posedge sys_clk);
    osc_mode <= rss_pkg::MODE_LF;
    sleeping <= 1'b1;
    @(posedge sys_clk);
    wdt_timeout <= 1'b1;
    @(posedge sys_clk);
    wdt_timeout <= 1'b0;
    finish_seq(2040, 2064, 1'b0, 1'b0, 4'hc);
  endtask

  // clear reset while asleep, external clock: no start-up delay
  task t_master_clear_n_sleep();
    @(posedge sys_clk);
    osc_mode <= rss_pkg::MODE_EC;
    sleeping <= 1'b1;
    master_clear_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    master_clear_n <= 1'b1;
    finish_seq(1, 6, 1'b0, 1'b0, 4'he);
  endtask

  // interrupt wake, for the given mode and interrupt-disable setting
  task t_wake(input rss_pkg::rss_osc_mode_t m, input logic gd,
              input int lo, input int hi, input logic [3:0] cs);
    @(posedge sys_clk);
    osc_mode <= m;
    global_interrupt_disable <= gd;
    sleeping <= 1'b1;
    @(posedge sys_clk);
    wake_int <= 1'b1;
    @(posedge sys_clk);
    wake_int <= 1'b0;
    finish_seq(lo, hi, 1'b1, ~gd, cs);
  endtask

  // supply dip, then clear low aborts the running timer; timing restarts
  // from the clear rising edge with the power-up timer only
  task t_abort();
    @(posedge sys_clk);
    osc_mode <= rss_pkg::MODE_EC;
    por_ok <= 1'b0;
    repeat (2) @(posedge sys_clk);
    por_ok <= 1'b1;
    repeat (10) @(posedge sys_clk);
    master_clear_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd_chk(rss_pkg::ADDR_SEQ_STAT, 8'h0f);
    @(posedge sys_clk);
    master_clear_n <= 1'b1;
    finish_seq(50, 56, 1'b0, 1'b0, 4'hf);
  endtask

  // sticky status, mask, write-one clear, re-raise, unmapped address
  task t_irq();
    rd_chk(rss_pkg::ADDR_IRQ_MASK, 8'h00);
    rd_chk(rss_pkg::ADDR_IRQ_STAT, 8'h0f);
    check({7'h00, irq}, 8'h00);
    wr_reg(rss_pkg::ADDR_IRQ_MASK, 8'h04);
    @(posedge sys_clk);
    #1;
    check({7'h00, irq}, 8'h01);
    wr_reg(rss_pkg::ADDR_IRQ_STAT, 8'h04);
    @(posedge sys_clk);
    #1;
    check({7'h00, irq}, 8'h00);
    rd_chk(rss_pkg::ADDR_IRQ_STAT, 8'h0b);
    rd_chk(8'h33, 8'h00);
    t_master_clear_n_run();
    #1;
    check({7'h00, irq}, 8'h01);
  endtask

  // verdict and end of run
  task complete_run();
    $display("errors %0d of %0d compares", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // main sequence; crystal start-up scenarios take about 2100 cycles each
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    t_por();
    t_master_clear_n_run();
    t_wdt_run();
    t_wdt_sleep();
    t_master_clear_n_sleep();
    t_wake(rss_pkg::MODE_XT, 1'b1, 2040, 2064, 4'he);
    t_wake(rss_pkg::MODE_EC, 1'b0, 1, 6, 4'ha);
    t_abort();
    t_irq();
    complete_run();
  end

  // hang guard, well beyond the expected run of about 6400 cycles
  initial begin
    #200000;
    err_count++;
    complete_run();
  end

endmodule
